// File: bench/sgs_checker.sv
// Port-level assertions for the gain set switcher.
// Bound onto sgs_gain_switch; mode digits shadowed from bus writes.
`timescale 1ns/1ps
module sgs_checker #(
    parameter MS_CYCLES = 4
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [1:0] wb_sel_i,
    input wire [15:0] wb_dat_i,
    input wire [15:0] wb_dat_o,
    input wire wb_ack_o,
    // Host command and loop state
    input wire gain_set_select_i,
    input wire cmd_executing_i,
    input wire motor_stopped_i,
    input wire position_mode_i,
    input wire [1:0] speed_loop_form_select_i,
    // Condition sources
    input wire positioning_done_flag_i,
    input wire near_position_i,
    input wire ref_filter_busy_i,
    input wire ref_input_active_i,
    // Watched gains
    input wire [15:0] mf_gain_o,
    input wire [15:0] mf_comp_o,
    input wire active_set_o
);
    // ==============================================================
    // Helper logic
    reg [7:0] cfg_reg; // Shadow of mode and condition digits
    wire auto_w = cfg_reg[3:0] == 4'h2;
    wire go_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire blk_w = cmd_executing_i || !motor_stopped_i;
    wire ap_w = auto_w && position_mode_i && !speed_loop_form_select_i[1];
    // Condition A per code, codes above 5 never true
    wire [5:0] cv_w = {ref_input_active_i,
        !ref_filter_busy_i && !ref_input_active_i, !near_position_i,
        near_position_i, !positioning_done_flag_i, positioning_done_flag_i};
    wire conda_w = (cfg_reg[7:4] < 4'h6) && cv_w[cfg_reg[6:4]];

    // Write lands at the take edge, as in the register
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= 8'h00;
        end else if (go_w && wb_we_i && wb_adr_i == 8'h00
                     && wb_sel_i[0]) begin
            cfg_reg <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Two cycles: skip mode change edges
    sequence s_auto2; auto_w ##1 auto_w; endsequence
    sequence s_blk2; blk_w ##1 blk_w; endsequence
    sequence s_ap2; ap_w ##1 (ap_w && conda_w != active_set_o); endsequence
    sequence s_off2;
        (auto_w && !position_mode_i && cfg_reg[7:4] < 4'h6
         && !speed_loop_form_select_i[1]) [*2];
    endsequence

    // ==============================================================
    // Assertions
    AST_ACK_TAKE:
        assert property (go_w |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_IDLE:
        assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_UNMAP_ZERO:
        assert property (go_w && !wb_we_i && wb_adr_i == 8'h20
                         |=> wb_dat_o == 16'h0000)
        else $error("unmapped read not zero");
    AST_STATUS_SET:
        assert property (go_w && !wb_we_i && wb_adr_i == 8'h14
            |=> wb_dat_o[1:0] == ($past(active_set_o) ? 2'h2 : 2'h1))
        else $error("status set code wrong");
    AST_MAN_SEL:
        assert property (!auto_w |=> active_set_o == $past(gain_set_select_i))
        else $error("manual set not following select");
    AST_MF_AUTO:
        assert property (s_auto2 |=> $stable(mf_gain_o) && $stable(mf_comp_o))
        else $error("model-following changed in auto mode");
    AST_MF_BUSY:
        assert property (s_blk2 |=> $stable(mf_gain_o) && $stable(mf_comp_o))
        else $error("model-following changed while busy");
    AST_AUTO_FLIP:
        assert property (s_ap2 |=> active_set_o == $past(conda_w))
        else $error("auto target not following condition");
    AST_POS_OFF:
        assert property (s_off2 |-> active_set_o == cfg_reg[4])
        else $error("fixed set wrong outside position control");
endmodule

bind sgs_gain_switch sgs_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);

// File: bench/sgs_gain_switch_tb_top.sv
// Self-checking bench for the gain set switcher.
// Assumes one 125 MHz clock and a shortened millisecond tick.
`timescale 1ns/1ps
module sgs_gain_switch_tb_top;
    localparam [111:0] DEF = {16'h0064, 16'h03e8, 16'h01f4, 16'h0064,
        16'h0190, 16'h07d0, 16'h0190}; // Set 1 defaults, slot 0 lowest
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg req = 1'b0; // Drives cyc and stb together
    reg wr = 1'b0, sel_req = 1'b0, run_req = 1'b0, pos_i = 1'b1;
    reg [7:0] adr = 8'h00;
    reg [15:0] wdat = 16'h0000;
    reg [1:0] form_i = 2'h0;
    reg done_i = 1'b0, near_i = 1'b0, busy_i = 1'b0, refin_i = 1'b0;
    reg [15:0] rd;
    wire [15:0] wb_dat_o;
    wire [15:0] g_w [0:6];
    wire wb_ack_o, act_w, gsel_w, cmd_w, stop_w;
    integer err_total = 0;
    integer num_checks = 0;
    integer i, c, p;

    sgs_host_model host_u (.clk_i(clk_i), .rst_i(rst_i),
        .sel_req_i(sel_req), .run_req_i(run_req),
        .gain_set_select_o(gsel_w), .cmd_executing_o(cmd_w),
        .motor_stopped_o(stop_w));
    sgs_gain_switch #(.MS_CYCLES(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(wr), .wb_adr_i(adr),
        .wb_sel_i(2'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .gain_set_select_i(gsel_w),
        .cmd_executing_i(cmd_w), .motor_stopped_i(stop_w),
        .position_mode_i(pos_i), .speed_loop_form_select_i(form_i),
        .positioning_done_flag_i(done_i), .near_position_i(near_i),
        .ref_filter_busy_i(busy_i), .ref_input_active_i(refin_i),
        .speed_gain_o(g_w[0]), .speed_int_time_o(g_w[1]),
        .position_gain_o(g_w[2]), .force_filter_time_o(g_w[3]),
        .mf_gain_o(g_w[4]), .mf_comp_o(g_w[5]),
        .friction_gain_o(g_w[6]), .active_set_o(act_w));

    initial forever #4 clk_i = ~clk_i;

    // ==============================================================
    // Tasks
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // Single classic cycle, held until ack is sampled
    task xfer(input [7:0] a, input w, input [15:0] d);
        integer n;
        begin
            @(posedge clk_i);
            req <= 1'b1;
            wr <= w;
            adr <= a;
            wdat <= d;
            n = 0;
            @(negedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 40) begin
                @(negedge clk_i);
                n = n + 1;
            end
            chk("bus ack", 16'h0001, {15'h0000, wb_ack_o});
            rd = wb_dat_o;
            @(posedge clk_i);
            req <= 1'b0;
        end
    endtask

    task rdchk(input [7:0] a, input [15:0] e, input string nm);
        begin
            xfer(a, 1'b0, 16'h0000);
            chk(nm, e, rd);
        end
    endtask

    // Bounded wait for position gain to reach or leave v
    task wait_pg(input [15:0] v, input eq);
        integer n;
        begin
            n = 0;
            while ((g_w[2] === v) != eq && n < 400) begin
                @(posedge clk_i);
                n = n + 1;
            end
        end
    endtask

    task close_out;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask

    // Watchdog well past the test length
    initial begin
        repeat (30000) @(posedge clk_i);
        err_total = err_total + 1;
        $display("BAD watchdog expired");
        close_out;
    end

    // ==============================================================
    // Tests
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h00, 16'h0000, "config reset");
        for (i = 0; i < 7; i = i + 1) begin
            rdchk(8'(8'h40 + 4 * i), DEF[16*i +: 16], "set1 slot");
            chk("gain out", DEF[16*i +: 16], g_w[i]);
        end
        rdchk(8'h14, 16'h0001, "status reset");
        xfer(8'h20, 1'b1, 16'h55aa);
        rdchk(8'h20, 16'h0000, "unmapped");
        $display("reset test done");
        // Manual switch while busy: mf pair must wait
        for (i = 0; i < 7; i = i + 1) xfer(8'(8'h5c + 4 * i), 1'b1,
            16'h0100 + i[15:0]);
        run_req <= 1'b1;
        sel_req <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("manual set", 16'h0001, {15'h0000, act_w});
        for (i = 0; i < 7; i = i + 1) chk("busy gain", (i == 4 || i == 5)
            ? DEF[16*i +: 16] : 16'h0100 + i[15:0], g_w[i]);
        run_req <= 1'b0;
        repeat (12) @(posedge clk_i);
        chk("mf gain", 16'h0104, g_w[4]);
        chk("mf comp", 16'h0105, g_w[5]);
        $display("manual test done");
        // Automatic, I-P form, wait 2 ms and ramp 4 ms toward set 2
        form_i <= 2'h1;
        xfer(8'h04, 1'b1, 16'h0002);
        xfer(8'h0c, 1'b1, 16'h0004);
        xfer(8'h00, 1'b1, 16'h0002);
        wait_pg(16'h0190, 1'b1);
        chk("back to set1", 16'h0190, g_w[2]);
        done_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("auto target", 16'h0001, {15'h0000, act_w});
        chk("held in wait", 16'h0190, g_w[2]);
        xfer(8'h14, 1'b0, 16'h0000);
        chk("status wait", 16'h000a, rd & 16'h001b);
        wait_pg(16'h0190, 1'b0);
        chk("ramp mid", 16'h0001, {15'h0000,
            g_w[2] < 16'h0190 && g_w[2] > 16'h0102});
        wait_pg(16'h0102, 1'b1);
        chk("ramp end", 16'h0102, g_w[2]);
        chk("mf kept", 16'h0104, g_w[4]);
        done_i <= 1'b0;
        wait_pg(16'h0190, 1'b1);
        done_i <= 1'b1;
        wait_pg(16'h0190, 1'b0);
        done_i <= 1'b0; // Reverse in mid-ramp
        repeat (3) @(posedge clk_i);
        chk("reverse target", 16'h0000, {15'h0000, act_w});
        wait_pg(16'h0190, 1'b1);
        chk("reverse gain", 16'h0190, g_w[2]);
        // Unsupported loop form inhibits switching
        form_i <= 2'h3;
        done_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("form inhibit", 16'h0000, {15'h0000, act_w});
        done_i <= 1'b0;
        form_i <= 2'h0;
        $display("auto test done");
        // Every condition code, sources low then high
        for (p = 0; p < 2; p = p + 1) begin
            for (c = 0; c < 6; c = c + 1) begin
                {done_i, near_i, busy_i, refin_i} <= {4{p[0]}};
                xfer(8'h00, 1'b1, {8'h00, c[3:0], 4'h2});
                repeat (4) @(posedge clk_i);
                chk("cond set", {15'h0000, 6'b011010 >> c} & 16'h0001
                    ^ {15'h0000, p[0]}, {15'h0000, act_w});
                pos_i <= 1'b0;
                repeat (4) @(posedge clk_i);
                chk("fixed set", {15'h0000, c[0]}, {15'h0000, act_w});
                pos_i <= 1'b1;
            end
        end
        $display("condition test done");
        close_out;
    end
endmodule

// File: bench/sgs_host_model.sv
// Host controller model: select bit and command activity.
// Assumes bench requests; motor rests a few cycles after a command.
`timescale 1ns/1ps
module sgs_host_model (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bench requests
    input wire sel_req_i,
    input wire run_req_i,
    // Command signals
    output reg gain_set_select_o,
    output reg cmd_executing_o,
    output reg motor_stopped_o
);
    reg [1:0] stop_reg; // Deceleration count after a command

    // Registered: changes follow a clock edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            gain_set_select_o <= 1'b0;
            cmd_executing_o <= 1'b0;
            motor_stopped_o <= 1'b1;
            stop_reg <= 2'h0;
        end else begin
            gain_set_select_o <= sel_req_i;
            cmd_executing_o <= run_req_i;
            motor_stopped_o <= !run_req_i && stop_reg == 2'h0;
            if (run_req_i) begin
                stop_reg <= 2'h3;
            end else if (stop_reg != 2'h0) begin
                stop_reg <= stop_reg - 2'h1;
            end
        end
    end
endmodule

// File: logic/sgs_gain_switch.v
// Servo gain set switcher: two gain sets, manual or automatic choice,
// waiting time and linear ramp between sets.
// Assumes loop inputs synchronous to clk_i and
// registers reached over classic Wishbone.
`timescale 1ns/1ps
`include "sgs_regs.vh"

module sgs_gain_switch #(
    parameter MS_CYCLES = `SGS_CLK_HZ / `SGS_MS_PER_S
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [1:0] wb_sel_i,
    input wire [15:0] wb_dat_i,
    output wire [15:0] wb_dat_o,
    output wire wb_ack_o,
    // Host command and loop state
    input wire gain_set_select_i,
    input wire cmd_executing_i,
    input wire motor_stopped_i,
    input wire position_mode_i,
    input wire [1:0] speed_loop_form_select_i,
    // Condition sources
    input wire positioning_done_flag_i,
    input wire near_position_i,
    input wire ref_filter_busy_i,
    input wire ref_input_active_i,
    // Effective gains
    output wire [15:0] speed_gain_o,
    output wire [15:0] speed_int_time_o,
    output wire [15:0] position_gain_o,
    output wire [15:0] force_filter_time_o,
    output wire [15:0] mf_gain_o,
    output wire [15:0] mf_comp_o,
    output wire [15:0] friction_gain_o,
    output wire active_set_o
);

    // =================================================================
    // Storage
    reg [15:0] gain_switch_configuration_reg; // Mode and condition
    reg [15:0] first_wait_time_reg; // Set 1 to 2 wait, ms
    reg [15:0] second_wait_time_reg; // Set 2 to 1 wait, ms
    reg [15:0] first_ramp_time_reg; // Set 1 to 2 ramp, ms
    reg [15:0] second_ramp_time_reg; // Set 2 to 1 ramp, ms
    reg [15:0] gain_reg [0:13]; // Set 1 in 0..6, set 2 in 7..13
    reg [15:0] eff_reg [0:6]; // Effective gains
    reg [15:0] from_reg [0:6]; // Ramp start values
    reg [15:0] dat_reg; // Read data
    reg ack_reg; // Bus acknowledge
    reg target_reg; // Set being moved to or held
    reg mf_set_reg; // Set used by model-following pair
    reg [1:0] state_reg; // Sequencer state
    reg [31:0] tick_cnt_reg; // Cycles within current ms
    reg [15:0] elapsed_reg; // Whole ms since phase start
    reg [15:0] wait_tot_reg; // Latched wait length
    reg [15:0] ramp_tot_reg; // Latched ramp length
    integer i;

    // =================================================================
    // Configuration decode
    wire [3:0] mode = gain_switch_configuration_reg[`SGS_MODE_MSB:
                                                    `SGS_MODE_LSB];
    wire [3:0] cond_sel = gain_switch_configuration_reg[`SGS_COND_MSB:
                                                        `SGS_COND_LSB];
    wire auto_mode = (mode == `SGS_MODE_AUTO);
    // Reserved mode acts as manual
    wire form_ok = (speed_loop_form_select_i == `SGS_FORM_PI) ||
                   (speed_loop_form_select_i == `SGS_FORM_IP);
    wire ms_tick = (tick_cnt_reg == MS_CYCLES - 1);

    // Condition A selection
    reg cond_a;
    always @* begin
        if (cond_sel == `SGS_COND_DONE_ON) begin
            cond_a = positioning_done_flag_i;
        end else if (cond_sel == `SGS_COND_DONE_OFF) begin
            cond_a = ~positioning_done_flag_i;
        end else if (cond_sel == `SGS_COND_NEAR_ON) begin
            cond_a = near_position_i;
        end else if (cond_sel == `SGS_COND_NEAR_OFF) begin
            cond_a = ~near_position_i;
        end else if (cond_sel == `SGS_COND_REF_IDLE) begin
            cond_a = ~ref_filter_busy_i & ~ref_input_active_i;
        end else if (cond_sel == `SGS_COND_REF_ON) begin
            cond_a = ref_input_active_i;
        end else begin
            // Undefined selection reads as false: never a switch toward set 2
            cond_a = 1'b0;
        end
    end

    // Fixed set outside position control: odd selections up to 5 hold set 2
    wire fixed_set = cond_sel[0] && (cond_sel <= `SGS_COND_REF_ON);
    wire auto_run = auto_mode && position_mode_i && form_ok;
    wire mf_allowed = ~cmd_executing_i & motor_stopped_i;

    // =================================================================
    // Linear blend per gain slot
    wire [15:0] blend [0:6];
    genvar g;
    generate
        for (g = 0; g < `SGS_NUM_GAINS; g = g + 1) begin : gen_blend
            wire signed [16:0] from_s = {1'b0, from_reg[g]};
            wire signed [16:0] to_s = {1'b0, gain_reg[target_reg ? g + 7 : g]};
            wire signed [16:0] diff = to_s - from_s;
            wire signed [33:0] prod = diff * $signed({1'b0, elapsed_reg});
            wire signed [33:0] den = $signed({18'h00000, ramp_tot_reg});
            wire signed [33:0] quot = (ramp_tot_reg == 16'h0000) ?
                                      34'sh0 : prod / den;
            wire signed [16:0] sum = from_s + quot[16:0];
            // Linear move from start value toward target set
            assign blend[g] = sum[15:0];
        end
    endgenerate

    // =================================================================
    // Wishbone slave: one wait state, ack one cycle after request
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire bus_wr = bus_req & wb_we_i;
    wire gain_hit = (wb_adr_i >= `SGS_ADR_GAIN_BASE) &&
                    (wb_adr_i <= `SGS_ADR_GAIN_LAST) &&
                    (wb_adr_i[1:0] == 2'h0);
    wire [7:0] gain_off = wb_adr_i - `SGS_ADR_GAIN_BASE;
    wire [3:0] gain_idx = gain_off[5:2];

    // Byte lane merge for writes
    function [15:0] merge;
        input [15:0] old;
        input [15:0] new_dat;
        input [1:0] sel;
        begin
            merge = {sel[1] ? new_dat[15:8] : old[15:8],
                     sel[0] ? new_dat[7:0] : old[7:0]};
        end
    endfunction

    // Register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            gain_switch_configuration_reg <= `SGS_RST_CONFIG;
            first_wait_time_reg <= `SGS_RST_TIME;
            second_wait_time_reg <= `SGS_RST_TIME;
            first_ramp_time_reg <= `SGS_RST_TIME;
            second_ramp_time_reg <= `SGS_RST_TIME;
            for (i = 0; i < 14; i = i + 7) begin
                gain_reg[i] <= `SGS_RST_SPD_GAIN;
                gain_reg[i + 1] <= `SGS_RST_SPD_INT;
                gain_reg[i + 2] <= `SGS_RST_POS_GAIN;
                gain_reg[i + 3] <= `SGS_RST_FILT;
                gain_reg[i + 4] <= `SGS_RST_MF_GAIN;
                gain_reg[i + 5] <= `SGS_RST_MF_COMP;
                gain_reg[i + 6] <= `SGS_RST_FRIC;
            end
        end else if (bus_wr) begin
            if (wb_adr_i == `SGS_ADR_CONFIG) begin
                gain_switch_configuration_reg <=
                    merge(gain_switch_configuration_reg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `SGS_ADR_WAIT1) begin
                first_wait_time_reg <=
                    merge(first_wait_time_reg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `SGS_ADR_WAIT2) begin
                second_wait_time_reg <=
                    merge(second_wait_time_reg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `SGS_ADR_RAMP1) begin
                first_ramp_time_reg <=
                    merge(first_ramp_time_reg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `SGS_ADR_RAMP2) begin
                second_ramp_time_reg <=
                    merge(second_ramp_time_reg, wb_dat_i, wb_sel_i);
            end else if (gain_hit) begin
                gain_reg[gain_idx] <=
                    merge(gain_reg[gain_idx], wb_dat_i, wb_sel_i);
            end
            // Unmapped writes dropped
        end
    end

    // Read data and acknowledge
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 16'h0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) begin
                if (wb_adr_i == `SGS_ADR_CONFIG) begin
                    dat_reg <= gain_switch_configuration_reg;
                end else if (wb_adr_i == `SGS_ADR_WAIT1) begin
                    dat_reg <= first_wait_time_reg;
                end else if (wb_adr_i == `SGS_ADR_WAIT2) begin
                    dat_reg <= second_wait_time_reg;
                end else if (wb_adr_i == `SGS_ADR_RAMP1) begin
                    dat_reg <= first_ramp_time_reg;
                end else if (wb_adr_i == `SGS_ADR_RAMP2) begin
                    dat_reg <= second_ramp_time_reg;
                end else if (wb_adr_i == `SGS_ADR_STATUS) begin
                    // Set code 1 or 2, model-following set, state
                    dat_reg <= {11'h000, state_reg, mf_set_reg,
                                target_reg, ~target_reg};
                end else if (gain_hit) begin
                    dat_reg <= gain_reg[gain_idx];
                end else begin
                    dat_reg <= 16'h0000;
                end
            end
        end
    end

    // =================================================================
    // Sequencer: decides target set, wait and ramp phases
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= `SGS_ST_IDLE;
            target_reg <= 1'b0;
            mf_set_reg <= 1'b0;
            tick_cnt_reg <= 32'h00000000;
            elapsed_reg <= 16'h0000;
            wait_tot_reg <= 16'h0000;
            ramp_tot_reg <= 16'h0000;
        end else begin
            // Ms time base, restarted per phase
            tick_cnt_reg <= ms_tick ? 32'h00000000 : tick_cnt_reg + 1;
            if (ms_tick && elapsed_reg != 16'hffff) begin
                elapsed_reg <= elapsed_reg + 16'h0001;
            end
            if (!auto_mode) begin
                // Manual selection steps at once, no ramp
                target_reg <= gain_set_select_i;
                state_reg <= `SGS_ST_IDLE;
                if (mf_allowed) begin
                    mf_set_reg <= gain_set_select_i;
                end
            end else if (!position_mode_i) begin
                target_reg <= fixed_set;
                state_reg <= `SGS_ST_IDLE;
            end else if (auto_run && cond_a != target_reg) begin
                // New or reversed transition restarts from current gains
                target_reg <= cond_a;
                state_reg <= `SGS_ST_WAIT;
                tick_cnt_reg <= 32'h00000000;
                elapsed_reg <= 16'h0000;
                wait_tot_reg <= cond_a ? first_wait_time_reg :
                                         second_wait_time_reg;
                ramp_tot_reg <= cond_a ? first_ramp_time_reg :
                                         second_ramp_time_reg;
            end else begin
                case (state_reg)
                    `SGS_ST_WAIT: begin
                        // Zero wait moves on in the next cycle
                        if (elapsed_reg >= wait_tot_reg) begin
                            state_reg <= `SGS_ST_RAMP;
                            tick_cnt_reg <= 32'h00000000;
                            elapsed_reg <= 16'h0000;
                        end
                    end
                    `SGS_ST_RAMP: begin
                        if (elapsed_reg >= ramp_tot_reg) begin
                            state_reg <= `SGS_ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= `SGS_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Start values are captured when a transition is armed
    wire arm = auto_mode && position_mode_i && auto_run &&
               (cond_a != target_reg);

    // =================================================================
    // Effective gain update
    always @(posedge clk_i) begin
        if (rst_i) begin
            eff_reg[0] <= `SGS_RST_SPD_GAIN;
            eff_reg[1] <= `SGS_RST_SPD_INT;
            eff_reg[2] <= `SGS_RST_POS_GAIN;
            eff_reg[3] <= `SGS_RST_FILT;
            eff_reg[4] <= `SGS_RST_MF_GAIN;
            eff_reg[5] <= `SGS_RST_MF_COMP;
            eff_reg[6] <= `SGS_RST_FRIC;
            for (i = 0; i < `SGS_NUM_GAINS; i = i + 1) begin
                from_reg[i] <= 16'h0000;
            end
        end else begin
            for (i = 0; i < `SGS_NUM_GAINS; i = i + 1) begin
                if (i == `SGS_IDX_MF_GAIN || i == `SGS_IDX_MF_COMP) begin
                    // Pair follows its own set, frozen in automatic
                    eff_reg[i] <= gain_reg[mf_set_reg ? i + 7 : i];
                end else if (arm) begin
                    from_reg[i] <= eff_reg[i];
                end else if (state_reg == `SGS_ST_RAMP &&
                             elapsed_reg < ramp_tot_reg) begin
                    eff_reg[i] <= blend[i];
                end else if (state_reg != `SGS_ST_WAIT) begin
                    // Whole set at once when settled
                    eff_reg[i] <= gain_reg[target_reg ? i + 7 : i];
                end
            end
        end
    end

    // =================================================================
    // Outputs
    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign speed_gain_o = eff_reg[0];
    assign speed_int_time_o = eff_reg[1];
    assign position_gain_o = eff_reg[2];
    assign force_filter_time_o = eff_reg[3];
    assign mf_gain_o = eff_reg[4];
    assign mf_comp_o = eff_reg[5];
    assign friction_gain_o = eff_reg[6];
    assign active_set_o = target_reg;

endmodule

// File: logic/sgs_regs.vh
// Register map, field positions, reset values and state codes for the
// servo gain set switcher.
// Assumes a 16-bit classic Wishbone slave with byte addresses.
//
// Contract
// - Digit zero picks manual or automatic switching
// - Manual select bit zero set 1, one set 2
// - Five gains switch together per set; model-following pair apart
// - Model-following values switch only in manual mode
// - Model-following switch needs idle and stopped motor
// - Automatic switching only in position control
// - Condition true: set 1 to 2, first times
// - Condition false: set 2 to 1, second times
// - Digit one selects which signal is condition A
// - Outside position control hold fixed set
// - Gain change waits for programmed waiting time
// - Gains ramp linearly within programmed switching time
// - Automatic switching in PI or I-P form
`ifndef SGS_REGS_VH
`define SGS_REGS_VH

// =====================================================================
// Register byte offsets
`define SGS_ADR_CONFIG 8'h00
`define SGS_ADR_WAIT1 8'h04
`define SGS_ADR_WAIT2 8'h08
`define SGS_ADR_RAMP1 8'h0c
`define SGS_ADR_RAMP2 8'h10
`define SGS_ADR_STATUS 8'h14
`define SGS_ADR_GAIN_BASE 8'h40
`define SGS_ADR_GAIN_LAST 8'h74

// =====================================================================
// Configuration fields and values
`define SGS_MODE_LSB 0
`define SGS_MODE_MSB 3
`define SGS_COND_LSB 4
`define SGS_COND_MSB 7
`define SGS_MODE_MANUAL 4'h0
`define SGS_MODE_AUTO 4'h2
`define SGS_COND_DONE_ON 4'h0
`define SGS_COND_DONE_OFF 4'h1
`define SGS_COND_NEAR_ON 4'h2
`define SGS_COND_NEAR_OFF 4'h3
`define SGS_COND_REF_IDLE 4'h4
`define SGS_COND_REF_ON 4'h5
`define SGS_FORM_PI 2'h0
`define SGS_FORM_IP 2'h1

// =====================================================================
// Reset values
`define SGS_RST_CONFIG 16'h0000
`define SGS_RST_TIME 16'h0000
`define SGS_RST_SPD_GAIN 16'h0190
`define SGS_RST_SPD_INT 16'h07d0
`define SGS_RST_POS_GAIN 16'h0190
`define SGS_RST_FILT 16'h0064
`define SGS_RST_MF_GAIN 16'h01f4
`define SGS_RST_MF_COMP 16'h03e8
`define SGS_RST_FRIC 16'h0064

// =====================================================================
// Gain slot indices inside one set
`define SGS_NUM_GAINS 7
`define SGS_IDX_MF_GAIN 4
`define SGS_IDX_MF_COMP 5

// =====================================================================
// Sequencer states
`define SGS_ST_IDLE 2'h0
`define SGS_ST_WAIT 2'h1
`define SGS_ST_RAMP 2'h2

// =====================================================================
// Timing
`define SGS_CLK_HZ 125000000
`define SGS_MS_PER_S 1000

`endif
